// File: design/hsp_cfg.svh
// Constants of the host port: timing counts, widths and reset values.
// Assumes a 10 MHz core clock and 8N1 framing on the host UART.
`ifndef HSP_CFG_SVH
`define HSP_CFG_SVH
// Core clock period in nanoseconds.
`define HSP_CLK_NS 100
// Host UART bit period in nanoseconds.
`define HSP_BIT_NS 8680
// Bit period in clock cycles, derived from the two times above.
`define HSP_BIT_CYC (`HSP_BIT_NS / `HSP_CLK_NS)
// Half a bit period, where the receiver samples the start bit.
`define HSP_HALF_CYC (`HSP_BIT_CYC / 2)
// Width of the bit timer.
`define HSP_TMR_W 7
// Data bits per character.
`define HSP_DATA_BITS 8
// Mode after reset: transparent.
`define HSP_MODE_RST 1'b0
// Idle level of the serial line.
`define HSP_LINE_IDLE 1'b1
// Carrier detect level with no lock or link.
`define HSP_DCD_RST 1'b1
`endif

// File: design/hsp_host_port.sv
// Host-facing pin logic: mode strap, UART with flow control, SPI pin
// directions, activity and carrier detect, two extra digital lines.
// Assumes all inputs are synchronous to clk_in at 10 MHz.
//
// Contract
// - strap low protocol, strap high transparent
// - no strap: software picks mode, transparent first
// - extra lines offer pull-up as input
// - extra lines drive configured power-on level
// - activity high while data moves
// - remote: carrier detect low when locked
// - base: carrier detect low when remotes connected
// - stop sending while host ready-input high; a character already started is still sent to its stop bit
// - transmit on UART out, receive on in
// - clear-to-send low when ready for data
// - slave select driven as master, input slave
// - MOSI output as master, input slave
// - MISO input as master, output slave
// - SCLK driven as master, input slave
// - reset input low resets the device
`timescale 1ns/1ps
`include "hsp_cfg.svh"
module hsp_host_port (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic mode_strap_in,
    input wire logic mode_strap_conn_in,
    input wire logic sw_mode_wr_in,
    input wire logic sw_protocol_in,
    output logic protocol_mode_out,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic host_rts_n_in,
    output logic uart_txd_out,
    input wire logic uart_rxd_in,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic accept_ready_in,
    output logic host_cts_n_out,
    input wire logic spi_master_in,
    input wire hsp_pkg::hsp_spi_t spi_core_in,
    input wire hsp_pkg::hsp_spi_t spi_pad_in,
    output hsp_pkg::hsp_spi_t spi_pad_out,
    output hsp_pkg::hsp_spi_t spi_pad_oe_n_out,
    output hsp_pkg::hsp_spi_t spi_core_out,
    input wire logic rf_activity_in,
    output logic activity_out,
    input wire logic base_role_in,
    input wire logic hop_locked_in,
    input wire logic [4:0] remote_count_in,
    output logic carrier_detect_n_out,
    input wire hsp_pkg::hsp_io_cfg_t io_cfg_a_in,
    input wire hsp_pkg::hsp_io_cfg_t io_cfg_b_in,
    input wire logic [1:0] io_wr_in,
    input wire logic [1:0] io_level_in,
    input wire logic [1:0] io_pad_in,
    output logic [1:0] io_pad_out,
    output logic [1:0] io_pad_oe_n_out,
    output logic [1:0] io_pull_up_en_out,
    output logic [1:0] io_value_out
);
    // -----------------------------------------------------------------
    // Mode selection
    // -----------------------------------------------------------------
    // Current mode, one means protocol.
    logic mode_q;

    // A connected strap overrides software; otherwise software decides.
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            mode_q <= `HSP_MODE_RST;
        end
        else if (mode_strap_conn_in)
        begin
            mode_q <= ~mode_strap_in;
        end
        else if (sw_mode_wr_in)
        begin
            mode_q <= sw_protocol_in;
        end
    end
    assign protocol_mode_out = mode_q;

    // -----------------------------------------------------------------
    // UART transmitter
    // -----------------------------------------------------------------
    // Transmit state, bit timer, bit index and shift register.
    hsp_pkg::hsp_ser_state_t tx_st_q;
    logic [`HSP_TMR_W-1:0] tx_tmr_q;
    logic [2:0] tx_idx_q;
    logic [7:0] tx_sh_q;
    logic txd_q;
    // End of the current bit period.
    logic tx_tick;
    assign tx_tick = (tx_tmr_q == `HSP_TMR_W'(`HSP_BIT_CYC - 1));
    // A new character starts only from idle with the host ready.
    assign tx_ready_out = (tx_st_q == hsp_pkg::HSP_IDLE) &&
        !host_rts_n_in;

    // Framer: start, eight data bits LSB first, stop.
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            tx_st_q <= hsp_pkg::HSP_IDLE;
            tx_tmr_q <= '0;
            tx_idx_q <= 3'h0;
            tx_sh_q <= 8'h00;
            txd_q <= `HSP_LINE_IDLE;
        end
        else
        begin
            tx_tmr_q <= (tx_st_q == hsp_pkg::HSP_IDLE || tx_tick) ? '0 :
                tx_tmr_q + `HSP_TMR_W'(1);
            unique case (tx_st_q)
                hsp_pkg::HSP_IDLE:
                begin
                    // Accept a character only while flow allows.
                    if (tx_valid_in && tx_ready_out)
                    begin
                        tx_sh_q <= tx_data_in;
                        txd_q <= 1'b0;
                        tx_st_q <= hsp_pkg::HSP_START;
                    end
                end
                hsp_pkg::HSP_START:
                begin
                    if (tx_tick)
                    begin
                        txd_q <= tx_sh_q[0];
                        tx_idx_q <= 3'h0;
                        tx_st_q <= hsp_pkg::HSP_DATA;
                    end
                end
                hsp_pkg::HSP_DATA:
                begin
                    // Ready-input is ignored here so the character ends.
                    if (tx_tick)
                    begin
                        if (tx_idx_q == 3'h7)
                        begin
                            txd_q <= 1'b1;
                            tx_st_q <= hsp_pkg::HSP_STOP;
                        end
                        else
                        begin
                            txd_q <= tx_sh_q[tx_idx_q + 3'h1];
                            tx_idx_q <= tx_idx_q + 3'h1;
                        end
                    end
                end
                hsp_pkg::HSP_STOP:
                begin
                    if (tx_tick)
                    begin
                        tx_st_q <= hsp_pkg::HSP_IDLE;
                    end
                end
            endcase
        end
    end
    assign uart_txd_out = txd_q;

    chk_rts_blocks_start: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (tx_st_q == hsp_pkg::HSP_IDLE && host_rts_n_in) |=>
        tx_st_q == hsp_pkg::HSP_IDLE)
        else $error("character started while host ready-input high");
    chk_char_completes: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (tx_st_q == hsp_pkg::HSP_DATA && tx_tick && host_rts_n_in) |=>
        (tx_st_q == hsp_pkg::HSP_STOP || tx_idx_q == $past(tx_idx_q) + 3'h1))
        else $error("character cut short by ready-input");
    chk_start_bit_low: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (tx_valid_in && tx_ready_out) |=> !uart_txd_out [*8])
        else $error("start bit not driven low");

    // -----------------------------------------------------------------
    // UART receiver
    // -----------------------------------------------------------------
    // Receive state, timer, index, shift register and outputs.
    hsp_pkg::hsp_ser_state_t rx_st_q;
    logic [`HSP_TMR_W-1:0] rx_tmr_q;
    logic [2:0] rx_idx_q;
    logic [7:0] rx_sh_q;
    logic [7:0] rx_data_q;
    logic rx_valid_q;
    // Middle of the start bit, and middle of each later bit.
    logic rx_half;
    logic rx_tick;
    assign rx_half = (rx_tmr_q == `HSP_TMR_W'(`HSP_HALF_CYC - 1));
    assign rx_tick = (rx_tmr_q == `HSP_TMR_W'(`HSP_BIT_CYC - 1));

    // Samples each bit near its centre; a short start is a glitch.
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            rx_st_q <= hsp_pkg::HSP_IDLE;
            rx_tmr_q <= '0;
            rx_idx_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end
        else
        begin
            rx_valid_q <= 1'b0;
            rx_tmr_q <= rx_tmr_q + `HSP_TMR_W'(1);
            unique case (rx_st_q)
                hsp_pkg::HSP_IDLE:
                begin
                    rx_tmr_q <= '0;
                    if (!uart_rxd_in)
                    begin
                        rx_st_q <= hsp_pkg::HSP_START;
                    end
                end
                hsp_pkg::HSP_START:
                begin
                    if (rx_half)
                    begin
                        rx_tmr_q <= '0;
                        rx_idx_q <= 3'h0;
                        rx_st_q <= uart_rxd_in ? hsp_pkg::HSP_IDLE :
                            hsp_pkg::HSP_DATA;
                    end
                end
                hsp_pkg::HSP_DATA:
                begin
                    if (rx_tick)
                    begin
                        rx_tmr_q <= '0;
                        rx_sh_q <= {uart_rxd_in, rx_sh_q[7:1]};
                        rx_idx_q <= rx_idx_q + 3'h1;
                        if (rx_idx_q == 3'h7)
                        begin
                            rx_st_q <= hsp_pkg::HSP_STOP;
                        end
                    end
                end
                hsp_pkg::HSP_STOP:
                begin
                    // A low stop bit is a framing error and is dropped.
                    if (rx_tick)
                    begin
                        rx_tmr_q <= '0;
                        rx_data_q <= rx_sh_q;
                        rx_valid_q <= uart_rxd_in;
                        rx_st_q <= hsp_pkg::HSP_IDLE;
                    end
                end
            endcase
        end
    end
    assign rx_data_out = rx_data_q;
    assign rx_valid_out = rx_valid_q;

    // Clear-to-send is low while the core can take host data.
    assign host_cts_n_out = ~accept_ready_in;

    chk_cts_follows: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        host_cts_n_out == !accept_ready_in)
        else $error("clear-to-send does not follow readiness");

    // -----------------------------------------------------------------
    // SPI pin directions, activity and carrier detect
    // -----------------------------------------------------------------
    // Registered SPI pad values and the core-side view of the pins.
    hsp_pkg::hsp_spi_t spi_out_q;
    hsp_pkg::hsp_spi_t spi_core_q;
    logic act_q;
    logic dcd_n_q;

    // Role-dependent enables: master drives select, MOSI and SCLK.
    always_comb
    begin
        spi_pad_oe_n_out.ss_n = ~spi_master_in;
        spi_pad_oe_n_out.mosi = ~spi_master_in;
        spi_pad_oe_n_out.sclk = ~spi_master_in;
        spi_pad_oe_n_out.miso = spi_master_in;
    end

    // Pad outputs and inputs are registered for both roles.
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            spi_out_q <= '1;
            spi_core_q <= '1;
        end
        else
        begin
            spi_out_q <= spi_core_in;
            spi_core_q <= spi_pad_in;
        end
    end
    assign spi_pad_out = spi_out_q;
    assign spi_core_out = spi_core_q;

    // Activity covers both UART directions and the radio side.
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            act_q <= 1'b0;
        end
        else
        begin
            act_q <= (tx_st_q != hsp_pkg::HSP_IDLE) ||
                (rx_st_q != hsp_pkg::HSP_IDLE) || rf_activity_in;
        end
    end
    assign activity_out = act_q;

    // Carrier detect by role: remote lock, or any connected remote.
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            dcd_n_q <= `HSP_DCD_RST;
        end
        else if (base_role_in)
        begin
            dcd_n_q <= (remote_count_in == 5'h00);
        end
        else
        begin
            dcd_n_q <= ~hop_locked_in;
        end
    end
    assign carrier_detect_n_out = dcd_n_q;

    chk_strap_mode: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        mode_strap_conn_in |=> protocol_mode_out == !$past(mode_strap_in))
        else $error("mode does not follow strap");
    chk_spi_master_dir: assert property (@(posedge clk_in)
        spi_master_in |-> (!spi_pad_oe_n_out.ss_n && !spi_pad_oe_n_out.mosi
        && !spi_pad_oe_n_out.sclk && spi_pad_oe_n_out.miso))
        else $error("master pin directions wrong");
    chk_activity_tx: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        tx_st_q == hsp_pkg::HSP_DATA |=> activity_out)
        else $error("activity low during transmission");
    chk_dcd_base: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (base_role_in && remote_count_in != 5'h00) |=>
        !carrier_detect_n_out)
        else $error("carrier detect high with remotes connected");
    chk_dcd_remote: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        (!base_role_in) |=> carrier_detect_n_out == !$past(hop_locked_in))
        else $error("remote carrier detect wrong");
    chk_reset_mode: assert property (@(posedge clk_in)
        !reset_n_in |=> (!protocol_mode_out && uart_txd_out))
        else $error("reset state wrong");

    // -----------------------------------------------------------------
    // Extra digital lines
    // -----------------------------------------------------------------
    // Line a.
    hsp_io_line u_line_a (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .cfg_in(io_cfg_a_in),
        .wr_in(io_wr_in[0]),
        .level_in(io_level_in[0]),
        .pad_in(io_pad_in[0]),
        .pad_out(io_pad_out[0]),
        .pad_oe_n_out(io_pad_oe_n_out[0]),
        .pull_up_en_out(io_pull_up_en_out[0]),
        .value_out(io_value_out[0])
    );
    // Line b.
    hsp_io_line u_line_b (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .cfg_in(io_cfg_b_in),
        .wr_in(io_wr_in[1]),
        .level_in(io_level_in[1]),
        .pad_in(io_pad_in[1]),
        .pad_out(io_pad_out[1]),
        .pad_oe_n_out(io_pad_oe_n_out[1]),
        .pull_up_en_out(io_pull_up_en_out[1]),
        .value_out(io_value_out[1])
    );
endmodule

// File: design/hsp_io_line.sv
// One configurable extra digital line with pull-up and power-on level.
// Assumes the pad combines out, oe_n and pull-up enable into the wire.
`timescale 1ns/1ps
module hsp_io_line (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire hsp_pkg::hsp_io_cfg_t cfg_in,
    input wire logic wr_in,
    input wire logic level_in,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n_out,
    output logic pull_up_en_out,
    output logic value_out
);
    // Driven level; loaded with the configured power-on level at reset.
    logic level_q;
    // Sampled pad level.
    logic value_q;

    // Output level: power-on level first, then software writes.
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            level_q <= cfg_in.init_level;
        end
        else if (wr_in)
        begin
            level_q <= level_in;
        end
    end

    // Input sample of the pad.
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            value_q <= 1'b0;
        end
        else
        begin
            value_q <= pad_in;
        end
    end

    assign pad_out = level_q;
    // Enable is low only while configured as output.
    assign pad_oe_n_out = ~cfg_in.is_output;
    // Pull-up is offered only while the line is an input.
    assign pull_up_en_out = ~cfg_in.is_output & cfg_in.pull_up;
    assign value_out = value_q;

    chk_pullup_input: assert property (@(posedge clk_in)
        pull_up_en_out |-> (!cfg_in.is_output && cfg_in.pull_up))
        else $error("pull-up enabled on an output line");
    chk_poweron_level: assert property (@(posedge clk_in)
        !reset_n_in ##1 (reset_n_in && !wr_in) |->
        pad_out == $past(cfg_in.init_level))
        else $error("power-on level not driven after reset");
endmodule

// File: design/hsp_pkg.sv
// Types shared by the host port and its extra digital line.
// Assumes hsp_cfg.svh is on the include path.
package hsp_pkg;
    // Four SPI pins, one bit each.
    typedef struct packed {
        logic ss_n;
        logic mosi;
        logic miso;
        logic sclk;
    } hsp_spi_t;
    // Configuration of one extra digital line.
    typedef struct packed {
        logic is_output;
        logic pull_up;
        logic init_level;
    } hsp_io_cfg_t;
    // One-hot states of a serial framer.
    typedef enum logic [3:0] {
        HSP_IDLE  = 4'h1,
        HSP_START = 4'h2,
        HSP_DATA  = 4'h4,
        HSP_STOP  = 4'h8
    } hsp_ser_state_t;
endpackage

// File: testbench/hsp_host_model.sv
// Host processor model: UART talker and listener with flow control.
// Assumes hsp_cfg.svh is on the include path and clk_in runs freely.
`timescale 1ns/1ps
`include "hsp_cfg.svh"
module hsp_host_model (
    input wire logic clk_in,
    input wire logic dev_txd_in,
    input wire logic dev_cts_n_in,
    output logic host_txd_out,
    output logic host_rts_n_out
);
    // -----------------------------------------------------------------
    // Line state
    // -----------------------------------------------------------------
    // The line idles high and the host starts out not ready to receive.
    initial
    begin
        host_txd_out = 1'b1;
        host_rts_n_out = 1'b1;
    end

    // Raises or lowers readiness off the sampling edge.
    task automatic set_ready(input logic rdy);
        @(negedge clk_in);
        host_rts_n_out = ~rdy;
    endtask

    // Sends one 8N1 character, LSB first, starting only once clear to send.
    task automatic send_byte(input logic [7:0] b, output logic ok);
        logic [9:0] frame;
        int n;
        frame = {1'b1, b, 1'b0};
        n = 0;
        ok = 1'b0;
        while (dev_cts_n_in !== 1'b0 && n < 2000)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n < 2000)
        begin
            ok = 1'b1;
            for (int i = 0; i < 10; i++)
            begin
                @(negedge clk_in);
                host_txd_out = frame[i];
                repeat (`HSP_BIT_CYC - 1) @(negedge clk_in);
            end
        end
    endtask

    // Waits for a start bit, then samples every bit near its middle.
    task automatic recv_byte(output logic [7:0] b, output logic ok,
                             input int lim);
        int n;
        n = 0;
        b = 8'h00;
        ok = 1'b0;
        while (dev_txd_in !== 1'b0 && n < lim)
        begin
            @(posedge clk_in);
            n++;
        end
        if (n < lim)
        begin
            repeat (`HSP_HALF_CYC) @(posedge clk_in);
            for (int i = 0; i < 8; i++)
            begin
                repeat (`HSP_BIT_CYC) @(posedge clk_in);
                b[i] = dev_txd_in;
            end
            repeat (`HSP_BIT_CYC) @(posedge clk_in);
            ok = dev_txd_in;
        end
    endtask
endmodule

// File: testbench/tb_hsp_host_port.sv
// Self-checking bench for the host port pins.
// Assumes the design files and hsp_host_model.sv are compiled first.
`timescale 1ns/1ps
module tb_hsp_host_port;
    // Mode steps: {strap connected, strap, sw write, sw value, expected}.
    localparam logic [4:0] MODE_TBL [5] = '{5'h07, 5'h04, 5'h11, 5'h15,
                                            5'h18};
    // Carrier steps: {base, locked, remote count, expected level}.
    localparam logic [7:0] DCD_TBL [5] = '{8'h40, 8'h01, 8'hc1, 8'h82,
                                           8'hbe};
    // Expected SPI enables and core view, indexed by master role.
    localparam logic [3:0] SPI_OE [2] = '{4'hd, 4'h2};
    localparam logic [3:0] SPI_CORE [2] = '{4'h7, 4'h8};
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic mode_strap_in = 1'b1;
    logic mode_strap_conn_in = 1'b0;
    logic sw_mode_wr_in = 1'b0;
    logic sw_protocol_in = 1'b0;
    logic protocol_mode_out;
    logic [7:0] tx_data_in = 8'h00;
    logic tx_valid_in = 1'b0;
    logic tx_ready_out;
    logic host_rts_n_in;
    logic uart_txd_out;
    logic uart_rxd_in;
    logic [7:0] rx_data_out;
    logic rx_valid_out;
    logic accept_ready_in = 1'b0;
    logic host_cts_n_out;
    logic spi_master_in = 1'b0;
    hsp_pkg::hsp_spi_t spi_core_in = 4'h0;
    hsp_pkg::hsp_spi_t spi_pad_in;
    hsp_pkg::hsp_spi_t spi_pad_out;
    hsp_pkg::hsp_spi_t spi_pad_oe_n_out;
    hsp_pkg::hsp_spi_t spi_core_out;
    logic [3:0] spi_ext = 4'h0;
    logic rf_activity_in = 1'b0;
    logic activity_out;
    logic base_role_in = 1'b0;
    logic hop_locked_in = 1'b0;
    logic [4:0] remote_count_in = 5'h00;
    logic carrier_detect_n_out;
    hsp_pkg::hsp_io_cfg_t io_cfg_a_in = 3'h5;
    hsp_pkg::hsp_io_cfg_t io_cfg_b_in = 3'h2;
    logic [1:0] io_wr_in = 2'h0;
    logic [1:0] io_level_in = 2'h0;
    logic [1:0] io_pad_in;
    logic [1:0] io_pad_out;
    logic [1:0] io_pad_oe_n_out;
    logic [1:0] io_pull_up_en_out;
    logic [1:0] io_value_out;
    logic [1:0] io_ext = 2'h0;
    logic [1:0] io_ext_en = 2'h0;
    int fail_count = 0;
    int compares = 0;

    // Pad levels: a driven pin shows its own value, else the far side, else an extra line shows its pull-up enable.
    assign spi_pad_in = (~spi_pad_oe_n_out & spi_pad_out)
                        | (spi_pad_oe_n_out & spi_ext);
    assign io_pad_in = (~io_pad_oe_n_out & io_pad_out)
                       | (io_pad_oe_n_out & io_ext_en & io_ext)
                       | (io_pad_oe_n_out & ~io_ext_en & io_pull_up_en_out);

    // The 10 MHz core clock.
    always #50 clk_in = ~clk_in;

    hsp_host_port u_hsp_host_port (
        .clk_in, .reset_n_in, .mode_strap_in, .mode_strap_conn_in,
        .sw_mode_wr_in, .sw_protocol_in, .protocol_mode_out,
        .tx_data_in, .tx_valid_in, .tx_ready_out, .host_rts_n_in,
        .uart_txd_out, .uart_rxd_in, .rx_data_out, .rx_valid_out,
        .accept_ready_in, .host_cts_n_out, .spi_master_in, .spi_core_in,
        .spi_pad_in, .spi_pad_out, .spi_pad_oe_n_out, .spi_core_out,
        .rf_activity_in, .activity_out, .base_role_in, .hop_locked_in,
        .remote_count_in, .carrier_detect_n_out, .io_cfg_a_in,
        .io_cfg_b_in, .io_wr_in, .io_level_in, .io_pad_in, .io_pad_out,
        .io_pad_oe_n_out, .io_pull_up_en_out, .io_value_out
    );

    hsp_host_model u_hsp_host_model (
        .clk_in,
        .dev_txd_in(uart_txd_out),
        .dev_cts_n_in(host_cts_n_out),
        .host_txd_out(uart_rxd_in),
        .host_rts_n_out(host_rts_n_in)
    );

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    // Steps to a later falling edge, where inputs change.
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // Compares a seen value with the expected one and counts both.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hands one character to the transmitter once it is taken.
    task automatic send_char(input logic [7:0] b);
        int n;
        n = 0;
        while (tx_ready_out !== 1'b1 && n < 3000)
        begin
            cyc(1);
            n++;
        end
        if (n == 3000)
        begin
            fail_count++;
            wrap_up();
        end
        tx_data_in = b;
        tx_valid_in = 1'b1;
        cyc(1);
        tx_valid_in = 1'b0;
    endtask

    // Lets the host listen for one character and compares it.
    task automatic recv_chk(input logic [7:0] exp);
        logic [7:0] b;
        logic ok;
        u_hsp_host_model.recv_byte(b, ok, 3000);
        check(ok, 1'b1);
        check(b, exp);
    endtask

    // Has the host send one character and waits for the receive pulse.
    task automatic rx_chk(input logic [7:0] exp);
        logic ok;
        int n;
        n = 0;
        fork
            u_hsp_host_model.send_byte(exp, ok);
            while (rx_valid_out !== 1'b1 && n < 3000)
            begin
                cyc(1);
                n++;
            end
        join
        check(ok, 1'b1);
        check(n < 3000, 1'b1);
        check(rx_data_out, exp);
    endtask

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial
    begin
        cyc(10);
        reset_n_in = 1'b1;
        // Values left by reset.
        check(uart_txd_out, 1'b1);
        check(protocol_mode_out, 1'b0);
        check(carrier_detect_n_out, 1'b1);
        check(io_pad_out, 2'h1);
        check(io_pad_oe_n_out, 2'h2);
        check(io_pull_up_en_out, 2'h2);
        // Software choice, then the strap overriding it.
        for (int i = 0; i < 5; i++)
        begin
            {mode_strap_conn_in, mode_strap_in, sw_mode_wr_in,
             sw_protocol_in} = MODE_TBL[i][4:1];
            cyc(1);
            sw_mode_wr_in = 1'b0;
            check(protocol_mode_out, MODE_TBL[i][0]);
        end
        // Output line written low; input line pulled up, then pulled low.
        io_wr_in = 2'h1;
        cyc(1);
        io_wr_in = 2'h0;
        cyc(1);
        check(io_pad_out, 2'h0);
        check(io_value_out, 2'h2);
        io_ext_en = 2'h2;
        cyc(1);
        check(io_value_out, 2'h0);
        // Both SPI roles: pin directions and data in each direction.
        spi_core_in = 4'ha;
        spi_ext = 4'h5;
        for (int m = 1; m >= 0; m--)
        begin
            spi_master_in = m[0];
            cyc(2);
            check(spi_pad_oe_n_out, SPI_OE[m]);
            check(spi_pad_out, 4'ha);
            check(spi_core_out, SPI_CORE[m]);
        end
        // Carrier detect in both roles, count at its boundaries.
        for (int i = 0; i < 5; i++)
        begin
            {base_role_in, hop_locked_in, remote_count_in} = DCD_TBL[i][7:1];
            cyc(1);
            check(carrier_detect_n_out, DCD_TBL[i][0]);
        end
        rf_activity_in = 1'b1;
        cyc(1);
        check(activity_out, 1'b1);
        rf_activity_in = 1'b0;
        // One character out while the host is ready.
        u_hsp_host_model.set_ready(1'b1);
        fork
            send_char(8'ha5);
            recv_chk(8'ha5);
            begin
                cyc(400);
                check(activity_out, 1'b1);
            end
        join
        // Back to back; readiness withdrawn mid-character.
        fork
            send_char(8'h5a);
            recv_chk(8'h5a);
            begin
                cyc(200);
                u_hsp_host_model.set_ready(1'b0);
            end
        join
        cyc(100);
        check(tx_ready_out, 1'b0);
        check(activity_out, 1'b0);
        // Held character leaves only once the host is ready again.
        fork
            send_char(8'hc3);
            recv_chk(8'hc3);
            begin
                cyc(300);
                check(uart_txd_out, 1'b1);
                u_hsp_host_model.set_ready(1'b1);
            end
        join
        // Host to device, clear to send raised and dropped.
        accept_ready_in = 1'b1;
        cyc(1);
        check(host_cts_n_out, 1'b0);
        rx_chk(8'h3c);
        rx_chk(8'h81);
        accept_ready_in = 1'b0;
        cyc(1);
        check(host_cts_n_out, 1'b1);
        // Reset in mid-character after a software mode change.
        mode_strap_conn_in = 1'b0;
        sw_mode_wr_in = 1'b1;
        sw_protocol_in = 1'b1;
        cyc(1);
        sw_mode_wr_in = 1'b0;
        send_char(8'h00);
        cyc(100);
        reset_n_in = 1'b0;
        cyc(1);
        check(uart_txd_out, 1'b1);
        check(protocol_mode_out, 1'b0);
        check(io_pad_out, 2'h1);
        check(carrier_detect_n_out, 1'b1);
        reset_n_in = 1'b1;
        cyc(2);
        wrap_up();
    end
endmodule
